// ### common/co2_defines.svh
`ifndef CO2_DEFINES_SVH
`define CO2_DEFINES_SVH
// Clock and time base.
`define CLK_HZ        50000000
`define CLK_PERIOD_NS 20
`define MS_NS         1000000
`define CYC_PER_MS    (`MS_NS / `CLK_PERIOD_NS)
// Serial character link.
`define BAUD_RATE     38400
`define CYC_PER_BIT   ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define FRAME_LEN     4'hc
// Timing figures in milliseconds.
`define UPDATE_MS     5000
`define WARMUP_MS     10000
`define ACCURACY_MS   300000
`define CAL_MIN_MS    600000
`define CAL_MAX_MS    1080000
`define PWM_PERIOD_MS 2000
`define PWM_START_MS  2
`define PWM_SPAN_MS   1000
// Pulse range and alarm thresholds in ppm.
`define RANGE_PPM     2000
`define ALARM_ON_PPM  16'h04b0
`define ALARM_OFF_PPM 16'h0320
// Characters.
`define CHR_SP        8'h20
`define CHR_ZERO      8'h30
`define CHR_P         8'h70
`define CHR_M         8'h6d
`define CHR_CR        8'h0d
`define CHR_LF        8'h0a
// Two-wire target address, command bytes and the zero response byte.
`define TWI_ADDR      7'h31
`define CMD_READ      8'h52
`define CMD_CAL_START 8'h4d
`define CMD_CAL_STOP  8'h53
`define RESP_ZERO     8'h00
`endif

// ### common/co2_pkg.sv
package co2_pkg;
  // One reading from the measurement core.
  typedef struct packed {
    logic [15:0] ppm;
    logic        valid;
  } reading_type;
  typedef enum logic [2:0] {
    TWI_IDLE = 3'b000, TWI_ADDR = 3'b001, TWI_AACK = 3'b010,
    TWI_WR   = 3'b011, TWI_WACK = 3'b100, TWI_RD   = 3'b101,
    TWI_RACK = 3'b110
  } twi_state_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_SHIFT = 2'b01
  } tx_state_type;
endpackage

// ### src/co2_outputs.sv
`timescale 1ns/100ps
`include "co2_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Character buffer between the frame builder and the serial transmitter.
module co2_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid_in & in_ready_out;
  wire              pop  = out_valid_out & out_ready_in;

  // Full and empty come straight from the fill count.
  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rd_r];

  // Storage array, written only on accepted pushes.
  always_ff @(posedge clk_sys_in) begin
    if (push) mem_r[wr_r] <= in_data_in;
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
      if (pop)  rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module co2_outputs #(
  parameter int CYC_PER_MS  = `CYC_PER_MS,
  parameter int CYC_PER_BIT = `CYC_PER_BIT,
  parameter int UPDATE_MS   = `UPDATE_MS,
  parameter int WARMUP_MS   = `WARMUP_MS,
  parameter int ACCURACY_MS = `ACCURACY_MS,
  parameter int CAL_MIN_MS  = `CAL_MIN_MS,
  parameter int CAL_MAX_MS  = `CAL_MAX_MS,
  parameter int RANGE_PPM   = `RANGE_PPM,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  input  wire co2_pkg::reading_type reading_in,
  input  wire logic                 cal_pin_in,
  input  wire logic                 uart_rx_in,
  output logic                      uart_tx_out,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_out,
  output logic                      pwm_out,
  output logic                      alarm_out,
  output logic                      ready_out,
  output logic                      accurate_out,
  output logic                      auto_baseline_calibration_out,
  output logic                      manual_calibration_out
);
  import co2_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  //////////////////////////////////////////////////////////////////////////
  // Millisecond time base, uptime and the five-second update strobe.
  logic [31:0] cyc_r, up_r, upd_ms_r;
  logic [15:0] ppm_r;
  logic        alarm_r, ready_r, accurate_r;
  wire ms_tick = (cyc_r == 32'(CYC_PER_MS - 1));
  wire upd     = ms_tick & (upd_ms_r == 32'(UPDATE_MS - 1));
  wire take    = upd & ready_r & reading_in.valid;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cyc_r <= '0;
      up_r <= '0;
      upd_ms_r <= '0;
    end else begin
      cyc_r <= ms_tick ? '0 : cyc_r + 32'd1;
      if (ms_tick && up_r != 32'(ACCURACY_MS)) up_r <= up_r + 32'd1;
      if (ms_tick) upd_ms_r <= upd ? '0 : upd_ms_r + 32'd1;
    end
  end

  // The value and the alarm change only on an update strobe.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ppm_r <= '0;
      alarm_r <= 1'b0;
      ready_r <= 1'b0;
      accurate_r <= 1'b0;
    end else begin
      ready_r <= (up_r >= 32'(WARMUP_MS));
      accurate_r <= (up_r >= 32'(ACCURACY_MS));
      if (take) begin
        ppm_r <= reading_in.ppm;
        if (reading_in.ppm >= `ALARM_ON_PPM) alarm_r <= 1'b1;
        else if (reading_in.ppm <= `ALARM_OFF_PPM) alarm_r <= 1'b0;
      end
    end
  end
  assign alarm_out = alarm_r;
  assign ready_out = ready_r;
  assign accurate_out = accurate_r;
  chk_alarm_hyst_on: assert property (take && reading_in.ppm >= 16'h04b0
    |=> alarm_out) else $error("alarm not raised at 1200 ppm");
  chk_alarm_hyst_off: assert property (take && reading_in.ppm <= 16'h0320
    |=> !alarm_out) else $error("alarm not cleared at 800 ppm");

  //////////////////////////////////////////////////////////////////////////
  // Serial frame builder. Stalls when the buffer is full.
  logic [7:0] dchar [6];
  logic [3:0] idx_r;
  logic       busy_r;
  logic [15:0] fr_ppm_r;
  logic [7:0] fbyte, tx_byte;
  logic       f_ready, t_valid, t_ready;
  wire        push = busy_r & f_ready;

  // Right-aligned decimal digits; the lowest digit always shows.
  for (genvar k = 0; k < 6; k++) begin : g_digit
    wire [31:0] q = {16'h0, fr_ppm_r} / 32'(10 ** k);
    wire        lead = (k != 0) && (q == 32'd0);
    assign dchar[k] = lead ? `CHR_SP : `CHR_ZERO + 8'(q % 32'd10);
  end

  // Byte order of a frame.
  assign fbyte = (idx_r < 4'd6)  ? dchar[3'd5 - 3'(idx_r)] :
                 (idx_r == 4'd6) ? `CHR_SP :
                 (idx_r < 4'd9)  ? `CHR_P :
                 (idx_r == 4'd9) ? `CHR_M :
                 (idx_r == 4'd10) ? `CHR_CR : `CHR_LF;

  // A frame that is still draining when the next value arrives is not cut;
  // its digits come from a copy taken at frame start, so none can mix.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_r <= 1'b0;
      idx_r <= '0;
      fr_ppm_r <= '0;
    end else if (!busy_r) begin
      busy_r <= take;
      idx_r <= '0;
      fr_ppm_r <= reading_in.ppm;
    end else if (push) begin
      idx_r <= idx_r + 4'd1;
      if (idx_r == `FRAME_LEN - 4'd1) busy_r <= 1'b0;
    end
  end
  chk_frame_crlf: assert property (
    push && idx_r > 4'd9 |-> fbyte == ((idx_r == 4'd10) ? 8'h0d : 8'h0a))
    else $error("frame end not CR LF");
  chk_frame_lead: assert property (push && idx_r == 4'd0 |-> fbyte == 8'h20)
    else $error("sixth digit of a 16-bit value not blank");

  co2_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .in_valid_in  (busy_r),
    .in_ready_out (f_ready),
    .in_data_in   (fbyte),
    .out_valid_out(t_valid),
    .out_ready_in (t_ready),
    .out_data_out (tx_byte)
  );

  //////////////////////////////////////////////////////////////////////////
  // Serial transmitter: start bit, eight data bits LSB first, stop bit.
  tx_state_type tx_st_r;
  logic [9:0]   tx_sh_r;
  logic [15:0]  tx_baud_r;
  logic [3:0]   tx_bit_r;
  wire tx_bit_end = (tx_baud_r == 16'(CYC_PER_BIT - 1));
  assign t_ready = (tx_st_r == TX_IDLE);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 10'h3ff;
      tx_baud_r <= '0;
      tx_bit_r <= '0;
    end else begin
      case (tx_st_r)
        TX_IDLE: if (t_valid) begin
          tx_sh_r <= {1'b1, tx_byte, 1'b0};
          tx_baud_r <= '0;
          tx_bit_r <= '0;
          tx_st_r <= TX_SHIFT;
        end
        TX_SHIFT: begin
          tx_baud_r <= tx_bit_end ? '0 : tx_baud_r + 16'd1;
          if (tx_bit_end) begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'd1;
            if (tx_bit_r == 4'd9) tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  assign uart_tx_out = tx_sh_r[0];
  chk_tx_stop_bit: assert property (tx_st_r == TX_SHIFT && tx_bit_r == 4'd9
    |-> uart_tx_out) else $error("stop bit not high");

  //////////////////////////////////////////////////////////////////////////
  // Serial receiver for the calibration command bytes.
  logic [15:0] rx_baud_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_busy_r, rx_done_r;
  wire rx_samp = rx_busy_r &
                 (rx_baud_r == 16'((CYC_PER_BIT - 1) / 2));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_baud_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        rx_busy_r <= !uart_rx_in;
        rx_baud_r <= '0;
        rx_bit_r <= '0;
      end else begin
        rx_baud_r <= (rx_baud_r == 16'(CYC_PER_BIT - 1)) ? '0
                   : rx_baud_r + 16'd1;
        if (rx_samp) begin
          rx_bit_r <= rx_bit_r + 4'd1;
          if (rx_bit_r == 4'd0 && uart_rx_in) rx_busy_r <= 1'b0;
          if (rx_bit_r != 4'd0 && rx_bit_r != 4'd9)
            rx_sh_r <= {uart_rx_in, rx_sh_r[7:1]};
          if (rx_bit_r == 4'd9) begin
            rx_busy_r <= 1'b0;
            rx_done_r <= uart_rx_in; // Framing error drops the byte.
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire target. Edges compare the live input with its value one clock earlier.
  twi_state_type tw_st_r;
  logic [7:0] tw_sh_r, tw_out_r;
  logic [3:0] tw_bit_r;
  logic [2:0] tw_idx_r;
  logic [15:0] resp_r;
  logic scl_q_r, sda_q_r, tw_nack_r, tw_cmd_r;
  logic [7:0] cfg_byte, resp_byte;
  wire scl_rise = scl_in & ~scl_q_r;
  wire scl_fall = ~scl_in & scl_q_r;
  wire tw_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire tw_stop  = scl_in & scl_q_r & ~sda_q_r & sda_in;
  wire byte_in  = scl_fall & (tw_bit_r == 4'd8);
  wire addr_hit = (tw_sh_r[7:1] == `TWI_ADDR);

  // Response layout: configuration, value high, value low, zero bytes.
  assign cfg_byte  = {5'h00, accurate_r, manual_calibration_out,
                      auto_baseline_calibration_out};
  assign resp_byte = (tw_idx_r == 3'd0) ? cfg_byte :
                     (tw_idx_r == 3'd1) ? resp_r[15:8] :
                     (tw_idx_r == 3'd2) ? resp_r[7:0] : `RESP_ZERO;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tw_st_r <= TWI_IDLE;
      {scl_q_r, sda_q_r} <= 2'b11;
      tw_sh_r <= '0;
      tw_out_r <= '0;
      tw_bit_r <= '0;
      tw_idx_r <= '0;
      tw_nack_r <= 1'b0;
      tw_cmd_r <= 1'b0;
      resp_r <= '0;
    end else begin
      {scl_q_r, sda_q_r} <= {scl_in, sda_in};
      tw_cmd_r <= 1'b0;
      if (scl_rise) tw_sh_r <= {tw_sh_r[6:0], sda_in};
      if (scl_rise) tw_bit_r <= tw_bit_r + 4'd1;
      if (tw_start) begin
        tw_st_r <= TWI_ADDR;
        tw_bit_r <= '0;
      end else if (tw_stop) begin
        tw_st_r <= TWI_IDLE;
      end else begin
        case (tw_st_r)
          TWI_ADDR: if (byte_in) begin
            tw_st_r <= addr_hit ? TWI_AACK : TWI_IDLE;
            tw_idx_r <= '0;
          end
          TWI_AACK: if (scl_fall) begin
            tw_bit_r <= '0;
            tw_out_r <= resp_byte;
            // The acknowledge bit has been shifted in; R/W is now bit 1.
            tw_st_r <= tw_sh_r[1] ? TWI_RD : TWI_WR;
          end
          TWI_WR: if (byte_in) begin
            tw_st_r <= TWI_WACK;
            tw_cmd_r <= 1'b1;
            if (tw_sh_r == `CMD_READ) resp_r <= ppm_r;
          end
          TWI_WACK: if (scl_fall) begin
            tw_bit_r <= '0;
            tw_st_r <= TWI_WR;
          end
          TWI_RD: if (scl_fall) begin
            tw_out_r <= {tw_out_r[6:0], 1'b0};
            tw_st_r <= (tw_bit_r == 4'd8) ? TWI_RACK : TWI_RD;
          end
          TWI_RACK: begin
            if (scl_rise) tw_nack_r <= sda_in;
            if (scl_fall) begin
              tw_bit_r <= '0;
              tw_idx_r <= tw_idx_r + 3'(tw_idx_r != 3'd7);
              tw_out_r <= (tw_idx_r == 3'd0) ? resp_r[15:8]
                        : (tw_idx_r == 3'd1) ? resp_r[7:0] : `RESP_ZERO;
              tw_st_r <= tw_nack_r ? TWI_IDLE : TWI_RD;
            end
          end
          default: tw_st_r <= TWI_IDLE;
        endcase
      end
    end
  end
  // Open drain: the pin is only ever pulled low, never driven high.
  assign sda_out = 1'b0;
  assign sda_oe_out = (tw_st_r == TWI_AACK) | (tw_st_r == TWI_WACK) |
                      ((tw_st_r == TWI_RD) & ~tw_out_r[7]);
  chk_twi_target_only: assert property (sda_oe_out |-> tw_st_r != TWI_IDLE
    && tw_st_r != TWI_ADDR) else $error("bus driven outside a transfer");
  chk_twi_zero_bytes: assert property (
    tw_st_r == TWI_RD && tw_idx_r >= 3'd3 |-> sda_oe_out)
    else $error("reserved byte not 0");

  //////////////////////////////////////////////////////////////////////////
  // Calibration mode. A stop before the minimum run waits for it.
  logic [31:0] cal_ms_r;
  logic        man_r, stop_pend_r, pin_q_r;
  wire cmd_start = (tw_cmd_r & (tw_sh_r == `CMD_CAL_START)) |
                   (rx_done_r & (rx_sh_r == `CMD_CAL_START)) |
                   (cal_pin_in & ~pin_q_r);
  wire cmd_stop  = (tw_cmd_r & (tw_sh_r == `CMD_CAL_STOP)) |
                   (rx_done_r & (rx_sh_r == `CMD_CAL_STOP)) |
                   (~cal_pin_in & pin_q_r);
  wire min_done  = (cal_ms_r >= 32'(CAL_MIN_MS));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      man_r <= 1'b0;
      stop_pend_r <= 1'b0;
      pin_q_r <= 1'b0;
      cal_ms_r <= '0;
    end else begin
      pin_q_r <= cal_pin_in;
      if (!man_r) begin
        man_r <= cmd_start;
        cal_ms_r <= '0;
        stop_pend_r <= 1'b0;
      end else begin
        if (ms_tick) cal_ms_r <= (cal_ms_r == 32'(CAL_MAX_MS - 1)) ? '0
                               : cal_ms_r + 32'd1;
        if (cmd_stop) stop_pend_r <= 1'b1;
        if ((cmd_stop | stop_pend_r) & min_done) man_r <= 1'b0;
      end
    end
  end
  assign manual_calibration_out = man_r;
  assign auto_baseline_calibration_out = ~man_r;
  chk_cal_min_run: assert property ($fell(man_r) |-> $past(cal_ms_r)
    >= 32'(CAL_MIN_MS)) else $error("manual calibration ended early");

  //////////////////////////////////////////////////////////////////////////
  // Pulse output, 2000 ms period; high time fixed at each period start.
  logic [31:0] per_ms_r, th_ms_r;
  logic        pwm_r;
  wire [31:0] clamp = ({16'h0, ppm_r} > 32'(RANGE_PPM)) ? 32'(RANGE_PPM)
                    : {16'h0, ppm_r};
  wire per_end = ms_tick & (per_ms_r == 32'(`PWM_PERIOD_MS - 1));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      per_ms_r <= '0;
      th_ms_r <= 32'(`PWM_START_MS);
      pwm_r <= 1'b0;
    end else begin
      if (ms_tick) per_ms_r <= per_end ? '0 : per_ms_r + 32'd1;
      if (per_end) th_ms_r <= 32'(`PWM_START_MS) +
          clamp * 32'(`PWM_SPAN_MS) / 32'(RANGE_PPM);
      pwm_r <= ready_r & (per_ms_r < th_ms_r);
    end
  end
  assign pwm_out = pwm_r;
  chk_pwm_period_wrap: assert property (per_ms_r < 32'd2000)
    else $error("pulse period beyond 2000 ms");
  chk_pwm_start_high: assert property (ready_r && per_ms_r == 32'd1 |=>
    pwm_out) else $error("pulse not high at period start");
endmodule

// ### verification/host_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Host side of the serial link: frame receiver and command sender.
module host_model #(
  parameter int CYC_PER_BIT = 8
) (
  input  wire logic clk_sys_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got [0:15];
  int         n_got;
  logic       lf_seen;
  logic [7:0] sh;

  // Forget what was captured so that a fresh frame can be collected.
  task automatic clear();
    n_got = 0;
    lf_seen = 1'b0;
  endtask

  // Start bit, eight data bits from the bottom up, then one stop bit.
  task automatic send(input logic [7:0] b);
    logic [8:0] fr;
    fr = {1'b1, b};
    @(posedge clk_sys_in);
    line_out <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (CYC_PER_BIT) @(posedge clk_sys_in);
      line_out <= fr[i];
    end
    repeat (CYC_PER_BIT + 2) @(posedge clk_sys_in);
  endtask

  // Bits are sampled mid-cell; a low stop bit drops the byte, as a real
  // host receiver would, so a baud error shows up as missing bytes.
  initial begin
    line_out = 1'b1;
    clear();
    forever begin
      @(negedge line_in);
      repeat (CYC_PER_BIT / 2) @(posedge clk_sys_in);
      for (int i = 0; i < 9; i++) begin
        repeat (CYC_PER_BIT) @(posedge clk_sys_in);
        if (i < 8) sh[i] = line_in;
      end
      if (line_in === 1'b1 && n_got < 16) begin
        got[n_got] = sh;
        n_got++;
        if (sh === 8'h0a) lf_seen = 1'b1;
      end
    end
  end
endmodule

// ### verification/test_co2_outputs.sv
`timescale 1ns/100ps
`define CHK_EQ(g, e) check(g, e)

////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the sensor output block.
module test_co2_outputs;
  import co2_pkg::*;
  localparam int MS   = 10;
  localparam int BIT  = 8;
  localparam int UPD  = 5;
  localparam int WARM = 3;
  localparam int ACC  = 20;
  localparam int CMIN = 10;
  localparam int CMAX = 18;
  localparam logic [7:0] TAIL [0:5] = '{8'h20, 8'h70, 8'h70, 8'h6d,
                                        8'h0d, 8'h0a};
  logic        clk_sys_in;
  logic        sys_rst_in;
  reading_type rd;
  logic        cal_pin, scl_m, sda_m, sda_line, a;
  logic        uart_tx, uart_rx, sda_drv, sda_oe, pwm, alarm;
  logic        ready, accurate, auto_cal, man_cal;
  logic [7:0]  q;
  int          n_mismatch, n_compared, n_cyc, n;

  // The bus is pulled up; either party may only pull it low.
  assign sda_line = (sda_oe && !sda_drv) ? 1'b0 : sda_m;

  co2_outputs #(.CYC_PER_MS(MS), .CYC_PER_BIT(BIT), .UPDATE_MS(UPD),
    .WARMUP_MS(WARM), .ACCURACY_MS(ACC), .CAL_MIN_MS(CMIN),
    .CAL_MAX_MS(CMAX)) u_co2_outputs (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reading_in(rd),
    .cal_pin_in(cal_pin), .uart_rx_in(uart_rx), .uart_tx_out(uart_tx),
    .scl_in(scl_m), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .pwm_out(pwm), .alarm_out(alarm),
    .ready_out(ready), .accurate_out(accurate),
    .auto_baseline_calibration_out(auto_cal),
    .manual_calibration_out(man_cal));

  host_model #(.CYC_PER_BIT(BIT)) u_host_model (
    .clk_sys_in(clk_sys_in), .line_in(uart_tx), .line_out(uart_rx));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers. Outputs are read at the rising edge, before that
  // edge's updates land, so every read is deterministic.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_char(input int v, input int k);
    if (k > 5) return TAIL[k-6];
    if (k < 5 && v < 10 ** (5 - k)) return 8'h20;
    return 8'h30 + 8'((v / 10 ** (5 - k)) % 10);
  endfunction

  // Waits for the end of a frame; the bound covers one frame plus a gap.
  task automatic wait_lf();
    u_host_model.clear();
    for (int i = 0; i < 4000 && !u_host_model.lf_seen; i++) cyc(1);
    if (!u_host_model.lf_seen) n_mismatch++;
  endtask

  task automatic twi_bit(input logic b, output logic r);
    sda_m <= b;
    cyc(6);
    scl_m <= 1'b1;
    cyc(6);
    r = sda_line;
    scl_m <= 1'b0;
  endtask

  task automatic twi_byte(input logic [7:0] d, input logic m,
                          output logic [7:0] rq, output logic ra);
    for (int i = 7; i >= 0; i--) twi_bit(d[i], rq[i]);
    twi_bit(m, ra);
  endtask

  task automatic twi_start();
    sda_m <= 1'b1;
    scl_m <= 1'b1;
    cyc(6);
    sda_m <= 1'b0;
    cyc(6);
    scl_m <= 1'b0;
  endtask

  task automatic twi_stop();
    sda_m <= 1'b0;
    cyc(6);
    scl_m <= 1'b1;
    cyc(6);
    sda_m <= 1'b1;
    cyc(6);
  endtask

  task automatic twi_cmd(input logic [7:0] c);
    twi_start();
    twi_byte(8'h62, 1'b1, q, a);
    `CHK_EQ(a, 1'b0);
    twi_byte(c, 1'b1, q, a);
    `CHK_EQ(a, 1'b0);
    twi_stop();
  endtask

  task automatic wait_pwm(input logic lvl);
    for (int i = 0; i < 25000 && pwm !== lvl; i++) cyc(1);
  endtask

  task automatic hold_len(input logic lvl);
    n = 0;
    while (pwm === lvl && n < 25000) begin
      cyc(1);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    cyc(1);
    `CHK_EQ(uart_tx, 1'b1);
    `CHK_EQ(sda_oe, 1'b0);
    `CHK_EQ(auto_cal, 1'b1);
    `CHK_EQ(man_cal, 1'b0);
    cyc(24);
    `CHK_EQ(ready, 1'b0);
    cyc(15);
    `CHK_EQ(ready, 1'b1);
    cyc(150);
    `CHK_EQ(accurate, 1'b0);
    cyc(25);
    `CHK_EQ(accurate, 1'b1);
  endtask

  task automatic t_uart(input int v);
    rd.ppm <= 16'(v);
    wait_lf();
    wait_lf();
    `CHK_EQ(u_host_model.n_got, 12);
    for (int k = 0; k < 12; k++) begin
      `CHK_EQ(u_host_model.got[k], exp_char(v, k));
    end
  endtask

  task automatic t_alarm();
    int   v [0:5];
    logic e [0:5];
    v = '{1199, 801, 800, 1199, 1200, 801};
    e = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      rd.ppm <= 16'(v[i]);
      cyc(60);
      `CHK_EQ(alarm, e[i]);
    end
    // A reading flagged invalid is refused, so the alarm keeps its state.
    rd <= '{16'h0000, 1'b0};
    cyc(60);
    `CHK_EQ(alarm, 1'b1);
    rd.valid <= 1'b1;
  endtask

  // Config byte is accurate, not manual, automatic: 0x05.
  task automatic t_twi();
    logic [7:0] exp [0:6];
    exp = '{8'h05, 8'h0a, 8'hbc, 8'h00, 8'h00, 8'h00, 8'h00};
    rd.ppm <= 16'h0abc;
    cyc(60);
    twi_start();
    twi_byte(8'h64, 1'b1, q, a);
    `CHK_EQ(a, 1'b1);
    twi_stop();
    twi_cmd(8'h52);
    twi_start();
    twi_byte(8'h63, 1'b1, q, a);
    `CHK_EQ(a, 1'b0);
    for (int k = 0; k < 7; k++) begin
      cyc(MS);
      twi_byte(8'hff, k == 6, q, a);
      `CHK_EQ(q, exp[k]);
    end
    twi_stop();
    `CHK_EQ(sda_oe, 1'b0);
  endtask

  // The stop lands after the minimum run and before the repeat point.
  task automatic cal_stop();
    cyc(6);
    `CHK_EQ(man_cal, 1'b1);
    cyc(40);
    u_host_model.send(8'h53);
    cyc(6);
    `CHK_EQ(man_cal, 1'b0);
  endtask

  task automatic t_cal();
    cal_pin <= 1'b1;
    cyc(6);
    `CHK_EQ(man_cal, 1'b1);
    `CHK_EQ(auto_cal, 1'b0);
    cal_pin <= 1'b0;
    cyc(85);
    `CHK_EQ(man_cal, 1'b1);
    cyc(30);
    `CHK_EQ(man_cal, 1'b0);
    `CHK_EQ(auto_cal, 1'b1);
    u_host_model.send(8'h4d);
    cal_stop();
    twi_cmd(8'h4d);
    cal_stop();
  endtask

  // 400 ppm of 2000: high 202 ms, low 1798 ms, at 10 cycles per ms.
  task automatic t_pwm();
    rd.ppm <= 16'd400;
    cyc(60);
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    hold_len(1'b1);
    `CHK_EQ(n, 2020);
    hold_len(1'b0);
    `CHK_EQ(n, 17980);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, main sequence and hang guard.
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    sys_rst_in = 1'b1;
    rd = '{16'h0000, 1'b1};
    cal_pin = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    cyc(2);
    sys_rst_in <= 1'b0;
    t_reset();
    t_uart(1255);
    t_uart(0);
    t_uart(10203);
    t_alarm();
    t_twi();
    t_cal();
    t_pwm();
    results();
  end

  // The whole run needs about 40000 cycles.
  always @(posedge clk_sys_in) begin
    n_cyc++;
    if (n_cyc == 90000) begin
      n_mismatch++;
      results();
    end
  end
endmodule
